//--- pkg/port_option_pkg.sv
package port_option_pkg;

   // Register map, byte addresses on the APB bus.
   localparam logic [11:0] FIRST_PORT_LATCH_ADDR = 12'h140;
   localparam logic [11:0] OPTION_STATUS_ADDR    = 12'h000;
   localparam logic [11:0] OPTION_FIRST_ADDR     = 12'h004;
   localparam logic [11:0] OPTION_SECOND_ADDR    = 12'h008;
   localparam logic [11:0] SECOND_PULLUP_ADDR    = 12'h00c;
   localparam logic [11:0] PROG_PORTS_ADDR       = 12'h010;
   localparam logic [11:0] DEVICE_ID_ADDR        = 12'h014;

   // Status register field positions.
   localparam int STAT_DONE_BIT   = 0;
   localparam int STAT_RW_EN_BIT  = 1;
   localparam int STAT_MODE_LSB   = 2;

   // Option word layout in nonvolatile memory.
   localparam logic [1:0] OPT_WORD_FIRST  = 2'h0;
   localparam logic [1:0] OPT_WORD_SECOND = 2'h1;
   localparam logic [1:0] OPT_WORD_SYSTEM = 2'h2;
   localparam int         OPT_WORD_COUNT  = 3;
   localparam int         SYS_RW_EN_BIT   = 0;
   localparam int         SYS_MODE_LSB    = 1;

   // Rewriting configurations.
   typedef enum logic [1:0] {
      RW_HV_FIRST = 2'h0,
      RW_HV_BUS   = 2'h1,
      RW_PIN_FIRST = 2'h2,
      RW_PIN_BUS  = 2'h3
   } rewrite_mode_type;

   // Extended ROM window reserved for the loader program.
   localparam logic [16:0] LOADER_ROM_START = 17'h14000;
   localparam logic [16:0] LOADER_ROM_END   = 17'h147ff;

   // Timing.
   localparam int CLK_PERIOD_NS     = 100;
   localparam int LOAD_TIME_US      = 3000;
   localparam int LOAD_CYCLES       = (LOAD_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int PULLUP_DELAY_US   = 200;
   localparam int PULLUP_CYCLES     = (PULLUP_DELAY_US * 1000) / CLK_PERIOD_NS;

   // Identification word, value is arbitrary.
   localparam logic [31:0] NEUTRAL_ID = 32'h0000_0000;

endpackage : port_option_pkg

//--- hdl/option_sync.sv
`timescale 1ns/1ps
module option_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input  wire logic             mclk_i,
   input  wire logic             rst_b_i,
   // Data.
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_type;

   sync_state_type state_reg;
   sync_state_type state_next;

   always_comb begin
      state_next        = state_reg;
      state_next.meta   = async_i;
      state_next.stable = state_reg.meta;
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sync_o = state_reg.stable;

endmodule : option_sync

//--- hdl/port_pad_ctrl.sv
`timescale 1ns/1ps
module port_pad_ctrl #(
   parameter int WIDTH = 8
) (
   // Configuration.
   input  wire logic [WIDTH-1:0] cmos_sel_i,
   input  wire logic [WIDTH-1:0] pullup_sel_i,
   input  wire logic             outputs_en_i,
   // Port data.
   input  wire logic [WIDTH-1:0] latch_i,
   input  wire logic [WIDTH-1:0] dir_out_i,
   // Pad drive.
   output logic      [WIDTH-1:0] pad_o,
   output logic      [WIDTH-1:0] pad_oe_o,
   output logic      [WIDTH-1:0] pad_pu_o
);

   // Each bit drives high only when CMOS, low always when enabled as output.
   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      always_comb begin
         pad_o[b]    = latch_i[b];
         pad_oe_o[b] = outputs_en_i & dir_out_i[b] & (cmos_sel_i[b] | ~latch_i[b]);
         pad_pu_o[b] = outputs_en_i & pullup_sel_i[b];
      end
   end

endmodule : port_pad_ctrl

//--- hdl/port_option_loader.sv
// Functional notes
// (RULE_01) Each first-port bit is either open drain without pull-up or CMOS with pull-up, chosen by a stored option.
// (RULE_02) Each second-port bit picks open drain or CMOS by option while its programmable pull-up stays available.
// (RULE_03) After reset release the options load within about 3 ms, then the program counter clears and the core runs.
// (RULE_04) All port output drivers stay disabled during reset and while options load.
// (RULE_05) CMOS first-port bits keep pull-up off during reset and briefly after, then become inputs with pull-up on.
// (RULE_06) Open-drain first-port bits, second-port bits and bus pin port bits are high-impedance inputs during reset.
// (RULE_07) Interrupt pin port and analog shared port keep outputs off and pull-ups off during and at reset release.
// (RULE_08) The outside circuit holds the reset input low at least 200 us after supply comes up.
// (RULE_09) Four rewriting modes exist: two by high voltage on reset, two by the mode enable pin, on first-port or bus pins.
// (RULE_10) In pin-driven rewriting modes the mode enable pin is pulled down, open drain, and its latch bit stays zero.
// The code adds no pull-down; the first-port bit 0 pull-up still follows its stored option.
// (RULE_11) With rewriting enabled, the loader program occupies the extended ROM region 14000h to 147FFh.
// (RULE_12) The device gives no answer to an automatic identification query.
// (RULE_13) The core stays in reset until every option bit is latched, and latched options stay fixed until reset.
`timescale 1ns/1ps
module port_option_loader #(
   parameter int LOAD_CYCLES   = port_option_pkg::LOAD_CYCLES,
   parameter int PULLUP_CYCLES = port_option_pkg::PULLUP_CYCLES,
   parameter int NVM_LATENCY   = 2
) (
   // Clock and reset.
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   // APB slave.
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Nonvolatile option memory read port.
   output logic      [1:0]  nvm_addr_o,
   output logic             nvm_rd_o,
   input  wire logic [7:0]  nvm_data_i,
   // Mode straps from pins.
   input  wire logic        high_voltage_reset_i,
   input  wire logic        mode_enable_pin_i,
   // Core control.
   output logic             core_reset_b_o,
   output logic             pc_clear_o,
   output logic [16:0]      loader_base_o,
   output logic             loader_rom_en_o,
   output logic             rewrite_active_o,
   output logic [1:0]       rewrite_mode_o,
   // First port pads.
   output logic [7:0]       first_port_o,
   output logic [7:0]       first_port_oe_o,
   output logic [7:0]       first_port_pu_o,
   // Second port pads.
   output logic [7:0]       second_port_o,
   output logic [7:0]       second_port_oe_o,
   output logic [7:0]       second_port_pu_o,
   // Bus pin, interrupt pin and analog shared ports.
   output logic [3:0]       bus_pin_port_oe_o,
   output logic [3:0]       interrupt_pin_port_oe_o,
   output logic [3:0]       interrupt_pin_port_pu_o,
   output logic [3:0]       analog_shared_port_oe_o,
   output logic [3:0]       analog_shared_port_pu_o
);

   initial begin
      if (LOAD_CYCLES < port_option_pkg::OPT_WORD_COUNT * (NVM_LATENCY + 1) + 1) begin
         $error("LOAD_CYCLES too small for option fetch");
      end
      if (PULLUP_CYCLES < 1 || PULLUP_CYCLES >= LOAD_CYCLES || NVM_LATENCY < 1) begin
         $error("bad timing parameters");
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // State.

   typedef enum logic [3:0] {
      ST_FETCH = 4'b0001,
      ST_WAIT  = 4'b0010,
      ST_HOLD  = 4'b0100,
      ST_RUN   = 4'b1000
   } load_state_type;

   typedef struct packed {
      load_state_type fsm;
      logic [31:0]    cycle_cnt;
      logic [7:0]     lat_cnt;
      logic [1:0]     word;
      logic [7:0]     first_cmos;
      logic [7:0]     second_cmos;
      logic           rw_enable;
      logic [1:0]     rw_mode;
      logic           pullup_on;
      logic           pc_clear;
      logic [7:0]     first_latch;
      logic [7:0]     first_dir;
      logic [7:0]     second_latch;
      logic [7:0]     second_dir;
      logic [7:0]     second_pullup;
      logic [31:0]    rdata;
   } loader_state_type;

   loader_state_type state_reg;
   loader_state_type state_next;

   logic [1:0] strap_sync;
   logic       apb_setup;
   logic       apb_access;

   //////////////////////////////////////////////////////////////////////////////
   // Strap synchronisers.

   option_sync #(
      .WIDTH (2)
   ) u_strap_sync (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .async_i ({high_voltage_reset_i, mode_enable_pin_i}),
      .sync_o  (strap_sync)
   );

   assign apb_setup  = psel_i & ~penable_i;
   assign apb_access = psel_i & penable_i;

   //////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      state_next          = state_reg;
      state_next.pc_clear = 1'b0;
      if (state_reg.fsm != ST_RUN) begin
         state_next.cycle_cnt = state_reg.cycle_cnt + 32'h0000_0001;
      end
      case (state_reg.fsm)
         ST_FETCH: begin
            state_next.lat_cnt = 8'h00;
            state_next.fsm     = ST_WAIT;
         end
         ST_WAIT: begin
            if (state_reg.lat_cnt == 8'(NVM_LATENCY - 1)) begin
               case (state_reg.word)
                  port_option_pkg::OPT_WORD_FIRST: begin
                     state_next.first_cmos = nvm_data_i;                            // [RULE_01]
                  end
                  port_option_pkg::OPT_WORD_SECOND: begin
                     state_next.second_cmos = nvm_data_i;                           // [RULE_02]
                  end
                  default: begin
                     state_next.rw_enable = nvm_data_i[port_option_pkg::SYS_RW_EN_BIT];
                     state_next.rw_mode   = strap_sync[1]                           // [RULE_09]
                        ? {1'b0, nvm_data_i[port_option_pkg::SYS_MODE_LSB]}
                        : {strap_sync[0], nvm_data_i[port_option_pkg::SYS_MODE_LSB]};
                  end
               endcase
               if (state_reg.word == port_option_pkg::OPT_WORD_SYSTEM) begin
                  state_next.fsm = ST_HOLD;
               end else begin
                  state_next.word = state_reg.word + 2'h1;
                  state_next.fsm  = ST_FETCH;
               end
            end else begin
               state_next.lat_cnt = state_reg.lat_cnt + 8'h01;
            end
         end
         ST_HOLD: begin
            if (state_reg.cycle_cnt >= 32'(PULLUP_CYCLES)) begin
               state_next.pullup_on = 1'b1;                                          // [RULE_05]
            end
            if (state_reg.cycle_cnt >= 32'(LOAD_CYCLES - 1)) begin
               state_next.fsm      = ST_RUN;                                         // [RULE_03] [RULE_13]
               state_next.pc_clear = 1'b1;
            end
         end
         ST_RUN: begin
            state_next.fsm = ST_RUN;
         end
         default: begin
            state_next.fsm = ST_FETCH;
         end
      endcase

      // Register access.
      if (apb_setup) begin
         case (paddr_i)
            port_option_pkg::OPTION_STATUS_ADDR: begin
               state_next.rdata = 32'h0000_0000;
               state_next.rdata[port_option_pkg::STAT_DONE_BIT] = (state_reg.fsm == ST_RUN);
               state_next.rdata[port_option_pkg::STAT_RW_EN_BIT] = state_reg.rw_enable;
               state_next.rdata[port_option_pkg::STAT_MODE_LSB +: 2] = state_reg.rw_mode;
            end
            port_option_pkg::OPTION_FIRST_ADDR: state_next.rdata = {24'h000000, state_reg.first_cmos};
            port_option_pkg::OPTION_SECOND_ADDR: state_next.rdata = {24'h000000, state_reg.second_cmos};
            port_option_pkg::FIRST_PORT_LATCH_ADDR: state_next.rdata = {24'h000000, state_reg.first_latch};
            port_option_pkg::SECOND_PULLUP_ADDR: state_next.rdata = {24'h000000, state_reg.second_pullup};
            port_option_pkg::PROG_PORTS_ADDR: state_next.rdata = {state_reg.second_dir, state_reg.second_latch,
                                                                   state_reg.first_dir, 8'h00};
            // No signature is offered to an identification query.
            port_option_pkg::DEVICE_ID_ADDR: state_next.rdata = 32'h0000_0000;       // [RULE_12]
            default: state_next.rdata = 32'h0000_0000;
         endcase
      end
      if (apb_access && pwrite_i && state_reg.fsm == ST_RUN) begin
         case (paddr_i)
            port_option_pkg::FIRST_PORT_LATCH_ADDR: begin
               state_next.first_latch = pwdata_i[7:0];
               if (state_reg.rw_mode[1] && state_reg.rw_enable) begin
                  state_next.first_latch[0] = 1'b0;                                  // [RULE_10]
               end
            end
            port_option_pkg::SECOND_PULLUP_ADDR: state_next.second_pullup = pwdata_i[7:0];
            port_option_pkg::PROG_PORTS_ADDR: begin
               state_next.first_dir    = pwdata_i[15:8];
               state_next.second_latch = pwdata_i[23:16];
               state_next.second_dir   = pwdata_i[31:24];
            end
            default: state_next.rdata = state_reg.rdata;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg     <= '0;                                                         // [RULE_04]
         state_reg.fsm <= ST_FETCH;
      end else begin
         state_reg <= state_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Port pads.

   logic outputs_en;
   logic [7:0] first_pu_sel;
   logic [7:0] first_cmos_eff;

   assign outputs_en     = (state_reg.fsm == ST_RUN);                                 // [RULE_04]
   assign first_pu_sel   = state_reg.pullup_on ? state_reg.first_cmos : 8'h00;        // [RULE_05] [RULE_06]
   assign first_cmos_eff = (state_reg.rw_enable && state_reg.rw_mode[1])
                           ? {state_reg.first_cmos[7:1], 1'b0} : state_reg.first_cmos; // [RULE_10]

   port_pad_ctrl #(
      .WIDTH (8)
   ) u_first_pads (
      .cmos_sel_i   (first_cmos_eff),
      .pullup_sel_i (first_pu_sel),
      .outputs_en_i (outputs_en),
      .latch_i      (state_reg.first_latch),
      .dir_out_i    (state_reg.first_dir),
      .pad_o        (first_port_o),
      .pad_oe_o     (first_port_oe_o),
      .pad_pu_o     ()
   );

   port_pad_ctrl #(
      .WIDTH (8)
   ) u_second_pads (
      .cmos_sel_i   (state_reg.second_cmos),
      .pullup_sel_i (state_reg.second_pullup),
      .outputs_en_i (outputs_en),
      .latch_i      (state_reg.second_latch),
      .dir_out_i    (state_reg.second_dir),
      .pad_o        (second_port_o),
      .pad_oe_o     (second_port_oe_o),
      .pad_pu_o     (second_port_pu_o)                                                 // [RULE_02] [RULE_06]
   );

   // First-port pull-up is an option, not gated by run state, so it rises with the option timer.
   assign first_port_pu_o         = first_pu_sel;                                     // [RULE_01] [RULE_05]
   assign bus_pin_port_oe_o       = 4'h0;                                             // [RULE_06]
   assign interrupt_pin_port_oe_o = 4'h0;                                             // [RULE_07]
   assign interrupt_pin_port_pu_o = 4'h0;                                             // [RULE_07]
   assign analog_shared_port_oe_o = 4'h0;                                             // [RULE_07]
   assign analog_shared_port_pu_o = 4'h0;                                             // [RULE_07]

   //////////////////////////////////////////////////////////////////////////////
   // Core and bus outputs.

   assign core_reset_b_o   = outputs_en;                                              // [RULE_13]
   assign pc_clear_o       = state_reg.pc_clear;                                      // [RULE_03]
   assign loader_rom_en_o  = state_reg.rw_enable;                                     // [RULE_11]
   assign loader_base_o    = state_reg.rw_enable ? port_option_pkg::LOADER_ROM_START : 17'h00000;
   assign rewrite_active_o = state_reg.rw_enable & (strap_sync[1] | strap_sync[0]);
   assign rewrite_mode_o   = state_reg.rw_mode;
   assign nvm_addr_o       = state_reg.word;
   assign nvm_rd_o         = (state_reg.fsm == ST_FETCH);
   assign prdata_o         = state_reg.rdata;
   assign pready_o         = 1'b1;
   assign pslverr_o        = 1'b0;

endmodule : port_option_loader

//--- bench/nvm_option_model.sv
`timescale 1ns/1ps
module nvm_option_model #(
   parameter int LAT = 2
) (
   // Clock and reset.
   input  wire logic            mclk_i,
   input  wire logic            rst_b_i,
   // Read port.
   input  wire logic [1:0]      nvm_addr_i,
   input  wire logic            nvm_rd_i,
   output logic      [7:0]      nvm_data_o,
   // Stored option words.
   input  wire logic [2:0][7:0] words_i
);
   logic [7:0] age_reg;
   logic [1:0] idx_reg;
   logic [7:0] word;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         age_reg <= 8'hff;
         idx_reg <= 2'h0;
      end else begin
         age_reg <= nvm_rd_i ? 8'h00 : ((age_reg == 8'hff) ? 8'hff : age_reg + 8'h01);
         if (nvm_rd_i) begin
            idx_reg <= nvm_addr_i;
         end
      end
   end

   assign word = (idx_reg == 2'h3) ? 8'h00 : words_i[idx_reg];
   // Outside the valid window the inverse shows, so stale data is never mistaken for a good read.
   assign nvm_data_o = (age_reg >= 8'(LAT - 1) && age_reg <= 8'(LAT)) ? word : ~word;
endmodule : nvm_option_model

//--- bench/port_option_loader_asserts.sv
`timescale 1ns/1ps
module port_option_loader_checker #(
   parameter int LOAD_CYCLES   = 30000,
   parameter int PULLUP_CYCLES = 2000
) (
   input wire logic        mclk_i,
   input wire logic        rst_b_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        core_reset_b_o,
   input wire logic        pc_clear_o,
   input wire logic [16:0] loader_base_o,
   input wire logic        loader_rom_en_o,
   input wire logic        rewrite_active_o,
   input wire logic [1:0]  rewrite_mode_o,
   input wire logic [7:0]  first_port_o,
   input wire logic [7:0]  first_port_oe_o,
   input wire logic [7:0]  first_port_pu_o,
   input wire logic [7:0]  second_port_oe_o,
   input wire logic [3:0]  bus_pin_port_oe_o,
   input wire logic [3:0]  interrupt_pin_port_oe_o,
   input wire logic [3:0]  interrupt_pin_port_pu_o,
   input wire logic [3:0]  analog_shared_port_oe_o,
   input wire logic [3:0]  analog_shared_port_pu_o
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [15:0] cnt_reg;

   // Counts cycles since reset release, saturating.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= (cnt_reg == 16'hffff) ? cnt_reg : cnt_reg + 16'h0001;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   ////////////////////////////////////////////////////////////////////////////////
   property p_no_drive; !core_reset_b_o |-> (first_port_oe_o | second_port_oe_o) == 8'h00; endproperty
   a_no_drive: assert property (p_no_drive) else $error("port driven while loading");
   property p_bus_off; bus_pin_port_oe_o == 4'h0; endproperty
   a_bus_off: assert property (p_bus_off) else $error("bus pin port driven");
   property p_aux_off; (interrupt_pin_port_oe_o | interrupt_pin_port_pu_o | analog_shared_port_oe_o
      | analog_shared_port_pu_o) == 4'h0; endproperty
   a_aux_off: assert property (p_aux_off) else $error("aux port active");
   property p_pu_late; 32'(cnt_reg) < PULLUP_CYCLES - 1 |-> first_port_pu_o == 8'h00; endproperty
   a_pu_late: assert property (p_pu_late) else $error("pull-up on too early");
   property p_hold_core; 32'(cnt_reg) < LOAD_CYCLES - 1 |-> !core_reset_b_o; endproperty
   a_hold_core: assert property (p_hold_core) else $error("core released early");
   property p_release; 32'(cnt_reg) > LOAD_CYCLES + 4 |-> core_reset_b_o && !pc_clear_o; endproperty
   a_release: assert property (p_release) else $error("core not released in time");
   property p_pc_pulse; pc_clear_o |=> !pc_clear_o [*2]; endproperty
   a_pc_pulse: assert property (p_pc_pulse) else $error("pc clear not one pulse");
   property p_fixed; core_reset_b_o |=> core_reset_b_o && $stable(rewrite_mode_o) && $stable(loader_rom_en_o);
   endproperty
   a_fixed: assert property (p_fixed) else $error("latched options changed");
   property p_loader; loader_rom_en_o |-> loader_base_o == 17'h14000; endproperty
   a_loader: assert property (p_loader) else $error("loader base wrong");
   property p_id; psel_i && penable_i && !pwrite_i && paddr_i == port_option_pkg::DEVICE_ID_ADDR
      |-> prdata_o == 32'h0; endproperty
   a_id: assert property (p_id) else $error("identification answered");
   property p_pin_bit; core_reset_b_o && rewrite_active_o && rewrite_mode_o[1] |-> !first_port_o[0]; endproperty
   a_pin_bit: assert property (p_pin_bit) else $error("mode pin latch high");
endmodule : port_option_loader_checker

//--- bench/port_option_loader_tb.sv
`timescale 1ns/1ps
module port_option_loader_tb;
   localparam int LOADC = 40;
   logic mclk_i, rst_b_i, psel, penable, pwrite, hv, mpin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata_o, rd;
   logic pready_o, pslverr_o, core_reset_b_o, pc_clear_o, loader_rom_en_o, rewrite_active_o, nvm_rd_o;
   logic [16:0] loader_base_o;
   logic [1:0] rewrite_mode_o, nvm_addr_o;
   logic [7:0] nvm_data_i, first_port_o, first_port_oe_o, first_port_pu_o;
   logic [7:0] second_port_o, second_port_oe_o, second_port_pu_o;
   logic [3:0] bp_oe, ip_oe, ip_pu, as_oe, as_pu;
   logic [2:0][7:0] words;
   int checks = 0;
   int n_mismatch = 0;
   int pc_n = 0;

   port_option_loader #(.LOAD_CYCLES(LOADC), .PULLUP_CYCLES(10), .NVM_LATENCY(2)) dut_u (
      .mclk_i, .rst_b_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o, .pready_o, .pslverr_o, .nvm_addr_o, .nvm_rd_o, .nvm_data_i,
      .high_voltage_reset_i(hv), .mode_enable_pin_i(mpin), .core_reset_b_o, .pc_clear_o, .loader_base_o,
      .loader_rom_en_o, .rewrite_active_o, .rewrite_mode_o, .first_port_o, .first_port_oe_o, .first_port_pu_o,
      .second_port_o, .second_port_oe_o, .second_port_pu_o, .bus_pin_port_oe_o(bp_oe),
      .interrupt_pin_port_oe_o(ip_oe), .interrupt_pin_port_pu_o(ip_pu), .analog_shared_port_oe_o(as_oe),
      .analog_shared_port_pu_o(as_pu));
   nvm_option_model #(.LAT(2)) nvm_u (.mclk_i, .rst_b_i, .nvm_addr_i(nvm_addr_o), .nvm_rd_i(nvm_rd_o),
      .nvm_data_o(nvm_data_i), .words_i(words));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) if (pc_clear_o === 1'b1) pc_n++;

   task automatic wrap_up();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge mclk_i);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge mclk_i);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge mclk_i); n++; end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) begin n_mismatch++; wrap_up(); end
      rd = prdata_o;
      chk(32'(pslverr_o), 32'h0, "slave error");
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic boot(input logic h, input logic p, input logic [7:0] sys);
      int n;
      int pc0;
      rst_b_i <= 1'b0; hv <= h; mpin <= p; words[2] <= sys;
      repeat (3) @(posedge mclk_i);
      chk({first_port_oe_o, first_port_pu_o, second_port_oe_o, 8'h00}, 32'h0, "pads in reset");
      chk({bp_oe, ip_oe, ip_pu, as_oe, as_pu, 11'h0, core_reset_b_o}, 32'h0, "aux in reset");
      pc0 = pc_n;
      rst_b_i <= 1'b1;
      n = 0;
      do begin
         @(negedge mclk_i);
         n++;
         if (core_reset_b_o !== 1'b1) chk(32'(first_port_oe_o | second_port_oe_o), 32'h0, "drive in load");
      end while (core_reset_b_o !== 1'b1 && n < LOADC + 20);
      if (core_reset_b_o !== 1'b1) begin n_mismatch++; wrap_up(); end
      chk(32'(n >= LOADC - 1 && n <= LOADC + 4), 32'h1, "load time");
      repeat (2) @(negedge mclk_i);
      chk(32'(pc_n - pc0), 32'h1, "pc clear pulse");
   endtask : boot

   task automatic t_ports();
      words[0] <= 8'h5a; words[1] <= 8'h3c;
      boot(1'b1, 1'b0, 8'h00);
      chk(32'(first_port_pu_o), 32'h5a, "first pull-ups");
      chk(32'({loader_rom_en_o, rewrite_active_o}), 32'h0, "no rewriting");
      apb(1'b0, port_option_pkg::OPTION_FIRST_ADDR, 32'h0);
      chk(rd, 32'h5a, "first options");
      apb(1'b0, port_option_pkg::OPTION_SECOND_ADDR, 32'h0);
      chk(rd, 32'h3c, "second options");
      apb(1'b0, port_option_pkg::DEVICE_ID_ADDR, 32'h0);
      chk(rd, 32'h0, "identification");
      apb(1'b0, 12'h0fc, 32'h0);
      chk(rd, 32'h0, "unmapped");
      apb(1'b1, port_option_pkg::SECOND_PULLUP_ADDR, 32'hff);
      @(negedge mclk_i);
      chk(32'(second_port_pu_o), 32'hff, "second pull-ups");
      apb(1'b1, port_option_pkg::FIRST_PORT_LATCH_ADDR, 32'h0f);
      apb(1'b1, port_option_pkg::PROG_PORTS_ADDR, 32'hff0fff00);
      @(negedge mclk_i);
      chk(32'(first_port_oe_o), 32'hfa, "open drain drive");
      chk({8'h00, second_port_o, second_port_oe_o, first_port_o}, 32'h000ffc0f, "port data");
      $display("test ports done");
   endtask : t_ports

   task automatic t_modes();
      logic [1:0] mm;
      for (int m = 0; m < 4; m++) begin
         mm = 2'(m);
         boot(!mm[1], mm[1], {6'h00, mm[0], 1'b1});
         chk(32'(rewrite_mode_o), 32'(mm), "mode");
         chk({13'h0, rewrite_active_o, loader_rom_en_o, loader_base_o}, 32'h00074000, "loader");
         apb(1'b0, port_option_pkg::OPTION_STATUS_ADDR, 32'h0);
         chk(32'(rd[3:0]), 32'({mm, 2'b11}), "status");
         apb(1'b1, port_option_pkg::FIRST_PORT_LATCH_ADDR, 32'hff);
         apb(1'b0, port_option_pkg::FIRST_PORT_LATCH_ADDR, 32'h0);
         chk(32'(rd[7:0]), mm[1] ? 32'hfe : 32'hff, "mode pin latch");
      end
      $display("test modes done");
   endtask : t_modes

   initial begin
      rst_b_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; hv = 1'b0; mpin = 1'b0; words = '0;
      t_ports();
      t_modes();
      wrap_up();
   end
endmodule : port_option_loader_tb

bind port_option_loader port_option_loader_checker #(.LOAD_CYCLES(LOAD_CYCLES), .PULLUP_CYCLES(PULLUP_CYCLES))
   chk_u (.mclk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .core_reset_b_o, .pc_clear_o,
   .loader_base_o, .loader_rom_en_o, .rewrite_active_o, .rewrite_mode_o, .first_port_o, .first_port_oe_o,
   .first_port_pu_o, .second_port_oe_o, .bus_pin_port_oe_o, .interrupt_pin_port_oe_o, .interrupt_pin_port_pu_o,
   .analog_shared_port_oe_o, .analog_shared_port_pu_o);
